/* pkg/ssf_pkg.sv */
// Package for the paged status readback and fuse programming block.
// Shared by the device end, the host end and the testbench.
package ssf_pkg;
   localparam int unsigned ssf_aw = 8;
   localparam int unsigned ssf_dw = 8;
   // Page codes
   localparam logic [7:0] ssf_page_master = 8'h00;
   localparam logic [7:0] ssf_page_clk_sup = 8'h01;
   localparam logic [7:0] ssf_page_input = 8'h02;
   localparam logic [7:0] ssf_page_output = 8'h03;
   localparam logic [7:0] ssf_page_loop_a = 8'h0a;
   localparam logic [7:0] ssf_page_loop_d = 8'h0d;
   localparam logic [7:0] ssf_page_reset = 8'h00;
   // Register offsets
   localparam logic [7:0] ssf_reg_lock_loss = 8'h02;
   localparam logic [7:0] ssf_reg_notify_mask = 8'h04;
   localparam logic [7:0] ssf_reg_fuse_burn = 8'h0f;
   localparam logic [7:0] ssf_reg_outer_cfg = 8'h17;
   localparam logic [7:0] ssf_reg_fuse_lock = 8'h2f;
   localparam logic [7:0] ssf_reg_ho_select = 8'hb3;
   localparam logic [7:0] ssf_reg_ho_data = 8'hb9;
   localparam logic [7:0] ssf_reg_state_data = 8'hd0;
   localparam logic [7:0] ssf_reg_state_sel = 8'hd1;
   localparam logic [7:0] ssf_reg_force_ovr = 8'he0;
   localparam logic [7:0] ssf_reg_force_en = 8'he1;
   localparam logic [7:0] ssf_reg_page = 8'hff;
   // Selectors and field values
   localparam logic [7:0] ssf_sel_state = 8'h40;
   localparam logic [7:0] ssf_sel_state_out = 8'h60;
   localparam logic [7:0] ssf_sel_state_loop = 8'h20;
   localparam logic [7:0] ssf_sel_holdover = 8'h0d;
   localparam logic [7:0] ssf_notify_unmask = 8'h01;
   localparam int unsigned ssf_ho_bit = 3;
   localparam int unsigned ssf_outer_off_bit = 7;
   localparam int unsigned ssf_wake_off_bit = 4;
   localparam logic [1:0] ssf_fuse_lock_val = 2'h1;
   localparam logic [4:0] ssf_fuse_burn_val = 5'h0c;
   localparam int unsigned ssf_nsect = 8;
   localparam int unsigned ssf_nforce = 7;
   localparam int unsigned ssf_state_reads = 3;
   localparam logic [7:0] ssf_reset_val = 8'h00;
   // Host command port registers
   localparam logic [3:0] ssf_cmd_ctrl = 4'h0;
   localparam logic [3:0] ssf_cmd_status = 4'h1;
   localparam logic [3:0] ssf_cmd_arg = 4'h2;
   localparam logic [3:0] ssf_cmd_result = 4'h3;
   // Host operation codes
   localparam logic [2:0] ssf_op_state = 3'h0;
   localparam logic [2:0] ssf_op_lock = 3'h1;
   localparam logic [2:0] ssf_op_holdover = 3'h2;
   localparam logic [2:0] ssf_op_fuse = 3'h3;
   localparam logic [2:0] ssf_op_wake_off = 3'h4;
   // Section state encodings per section class
   typedef enum {ssf_sect_idle, ssf_sect_wait, ssf_sect_active} ssf_sect_state_t;
   localparam logic [7:0] ssf_code_master_wait = 8'd9;
   localparam logic [7:0] ssf_code_master_act = 8'd36;
   localparam logic [7:0] ssf_code_clk_wait = 8'd5;
   localparam logic [7:0] ssf_code_clk_act = 8'd12;
   localparam logic [7:0] ssf_code_in_wait = 8'd7;
   localparam logic [7:0] ssf_code_in_act = 8'd23;
   localparam logic [7:0] ssf_code_out_wait = 8'd12;
   localparam logic [7:0] ssf_code_out_act = 8'd20;
   localparam logic [7:0] ssf_code_loop_wait = 8'd8;
   localparam logic [7:0] ssf_code_loop_act = 8'd48;
   localparam logic [7:0] ssf_code_idle = 8'd0;
endpackage

/* pkg/ssf_if.sv */
// Paged register link between the host controller and the device.
// Read data stand one cycle after the read strobe.
`timescale 1ns/1ps
interface ssf_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   modport device (input addr, input wdata, input wr, input rd, output rdata);
   modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface

/* logic/ssf_sect_state.sv */
// One section's state code as read back through the status data register.
// Assumes the section state is a stable level from the device's own logic.
`timescale 1ns/1ps
module ssf_sect_state
   import ssf_pkg::*;
#(
   parameter logic [7:0] wait_code = 8'd9,
   parameter logic [7:0] act_code = 8'd36
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic powered,
   input wire logic active,
   output logic [7:0] code
);
   wire logic [7:0] next_code;
   // Held in a flop so repeated reads agree
   assign next_code = !powered ? ssf_code_idle : (active ? act_code : wait_code);
   always_ff @(posedge clk) begin
      if (rst) begin
         code <= ssf_code_idle;
      end else begin
         code <= next_code; // see R20
      end
   end
endmodule

/* logic/ssf_device.sv */
// Device end: paged register file, section state readback, loop status
// and fuse programming sequence. Host is the only master on the link.
// Operation
// R1: page codes 0-3 select master, supervision, input, output
// R2: page codes 0x0A-0x0D select loops A-D
// R3: master selector 0x40 reads 9, 0, 36
// R4: supervision selector 0x40 low bits read 5, 0, 12
// R5: input selector 0x40 low bits read 7, 0, 23
// R6: output selector 0x60 reads 12, 0, 20
// R7: loop selector 0x20 reads 8, 0, 48
// R8: host reads status data three times
// R9: host waits for master wait state first; the host end does not wait for it
// R10: unmasked loop bit 0 shows unlock
// R11: outer loop disabled bit reads holdover profile
// R12: holdover select 0x0D, then bit 3 reads holdover
// R13: force override bits for seven sections
// R14: forced enable bits power seven sections
// R15: host powers section before fuse command; the host end writes no force bits before it
// R16: bits 7:6 value 1 locks page fuses
// R17: bits 7:3 value 0x0C burns page fuses
// R18: master bit 4 removes manual wake-up
// R19: page select applies at once, reads back
// R20: status data stable across repeated reads
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module ssf_device
   import ssf_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   ssf_if.device link,
   input wire logic [3:0] loop_unlocked,
   input wire logic [3:0] loop_holdover,
   input wire logic [ssf_nsect-1:0] sect_active,
   output logic [ssf_nsect-1:0] sect_powered,
   output logic [ssf_nsect-1:0] fuse_locked,
   output logic [ssf_nsect-1:0] fuse_burn,
   output logic manual_wake_off,
   output logic [7:0] current_page
);
   // Section index: 0 master, 1 supervision, 2 input, 3 output, 4-7 loops
   logic [7:0] page;
   logic [7:0] state_sel [ssf_nsect];
   logic [7:0] fuse_reg [ssf_nsect];
   logic [7:0] mask_reg [4];
   logic [7:0] outer_cfg [4];
   logic [7:0] ho_sel [4];
   logic [6:0] force_ovr;
   logic [6:0] force_en;
   logic [7:0] burn_reg [ssf_nsect];
   logic [7:0] rdata;
   wire logic [7:0] codes [ssf_nsect];
   wire logic is_loop;
   wire logic page_valid;
   wire logic [2:0] sidx;
   wire logic [1:0] lidx;
   wire logic [7:0] state_val;
   wire logic [7:0] sel_need;
   wire logic [7:0] next_rdata;
   wire logic [ssf_nsect-1:0] powered;
   wire logic wr_burn;
   wire logic [6:0] forced;

   assign is_loop = page >= ssf_page_loop_a && page <= ssf_page_loop_d; // see R2
   assign page_valid = is_loop || page <= ssf_page_output; // see R1
   assign lidx = 2'(page - ssf_page_loop_a);
   assign sidx = is_loop ? {1'b1, lidx} : page[2:0];
   // Master always on; subordinates only by forced power-up
   // Force bit 0 is input, bit 1 supervision
   assign forced = force_ovr & force_en; // see R13 R14
   assign powered = {forced[6:3], forced[2], forced[0], forced[1], 1'b1};

   ssf_sect_state #(.wait_code(ssf_code_master_wait), .act_code(ssf_code_master_act))
      u_m (.clk(clk), .rst(rst), .powered(powered[0]), .active(sect_active[0]),
           .code(codes[0])); // see R3
   ssf_sect_state #(.wait_code(ssf_code_clk_wait), .act_code(ssf_code_clk_act))
      u_c (.clk(clk), .rst(rst), .powered(powered[1]), .active(sect_active[1]),
           .code(codes[1])); // see R4
   ssf_sect_state #(.wait_code(ssf_code_in_wait), .act_code(ssf_code_in_act))
      u_i (.clk(clk), .rst(rst), .powered(powered[2]), .active(sect_active[2]),
           .code(codes[2])); // see R5
   ssf_sect_state #(.wait_code(ssf_code_out_wait), .act_code(ssf_code_out_act))
      u_o (.clk(clk), .rst(rst), .powered(powered[3]), .active(sect_active[3]),
           .code(codes[3])); // see R6
   for (genvar g = 4; g < ssf_nsect; g++) begin : g_loop
      ssf_sect_state #(.wait_code(ssf_code_loop_wait), .act_code(ssf_code_loop_act))
         u_l (.clk(clk), .rst(rst), .powered(powered[g]), .active(sect_active[g]),
              .code(codes[g])); // see R7
   end

   assign sel_need = sidx == 3'd3 ? ssf_sel_state_out :
                     (is_loop ? ssf_sel_state_loop : ssf_sel_state); // see R6 R7
   // Supervision shows four bits, input and output five
   assign state_val = state_sel[sidx] != sel_need ? ssf_reset_val :
                      sidx == 3'd1 ? {4'h0, codes[1][3:0]} :
                      (sidx == 3'd2 || sidx == 3'd3) ? {3'h0, codes[sidx][4:0]} :
                      codes[sidx]; // see R4 R5

   function automatic logic [7:0] rd_mux(input logic [7:0] a);
      logic [7:0] v;
      v = ssf_reset_val;
      case (a)
         ssf_reg_page: v = page; // see R19
         ssf_reg_state_data: v = state_val; // see R3 R20
         ssf_reg_state_sel: v = state_sel[sidx];
         ssf_reg_fuse_burn: v = burn_reg[sidx];
         ssf_reg_fuse_lock: v = fuse_reg[sidx];
         ssf_reg_force_ovr: v = sidx == 3'd0 ? {1'b0, force_ovr} : ssf_reset_val;
         ssf_reg_force_en: v = sidx == 3'd0 ? {1'b0, force_en} : ssf_reset_val;
         ssf_reg_notify_mask: v = is_loop ? mask_reg[lidx] : ssf_reset_val;
         ssf_reg_lock_loss: v = is_loop ?
            {7'h0, mask_reg[lidx][0] & loop_unlocked[lidx]} : ssf_reset_val; // see R10
         ssf_reg_outer_cfg: v = is_loop ? outer_cfg[lidx] : ssf_reset_val; // see R11
         ssf_reg_ho_select: v = is_loop ? ho_sel[lidx] : ssf_reset_val;
         ssf_reg_ho_data: v = (is_loop && ho_sel[lidx] == ssf_sel_holdover) ?
            8'(32'(loop_holdover[lidx] | outer_cfg[lidx][ssf_outer_off_bit]) << ssf_ho_bit) :
            ssf_reset_val; // see R12 R11
         default: v = ssf_reset_val;
      endcase
      return v;
   endfunction

   assign next_rdata = link.rd ? rd_mux(link.addr) : ssf_reset_val;
   assign wr_burn = link.wr && link.addr == ssf_reg_fuse_burn && page_valid;

   always_ff @(posedge clk) begin
      if (rst) begin
         page <= ssf_page_reset;
         force_ovr <= 7'h00;
         force_en <= 7'h00;
         manual_wake_off <= 1'b0;
         rdata <= ssf_reset_val;
         for (int i = 0; i < ssf_nsect; i++) begin
            state_sel[i] <= ssf_reset_val;
            fuse_reg[i] <= ssf_reset_val;
            burn_reg[i] <= ssf_reset_val;
         end
         for (int i = 0; i < 4; i++) begin
            mask_reg[i] <= ssf_reset_val;
            outer_cfg[i] <= ssf_reset_val;
            ho_sel[i] <= ssf_reset_val;
         end
      end else begin
         rdata <= next_rdata;
         if (link.wr && link.addr == ssf_reg_page) begin
            page <= link.wdata; // see R19 R1
         end
         if (link.wr && page_valid) begin
            case (link.addr)
               ssf_reg_state_sel: state_sel[sidx] <= link.wdata;
               ssf_reg_fuse_lock: fuse_reg[sidx] <= link.wdata; // see R16
               ssf_reg_fuse_burn: burn_reg[sidx] <= link.wdata;
               ssf_reg_force_ovr: if (sidx == 3'd0) force_ovr <= link.wdata[6:0];
               ssf_reg_force_en: if (sidx == 3'd0) force_en <= link.wdata[6:0];
               ssf_reg_notify_mask: if (is_loop) mask_reg[lidx] <= link.wdata;
               ssf_reg_outer_cfg: if (is_loop) outer_cfg[lidx] <= link.wdata;
               ssf_reg_ho_select: if (is_loop) ho_sel[lidx] <= link.wdata;
               default: ;
            endcase
            if (link.addr == ssf_reg_fuse_lock && sidx == 3'd0) begin
               manual_wake_off <= link.wdata[ssf_wake_off_bit]; // see R18
            end
         end
      end
   end

   assign link.rdata = rdata;

   always_ff @(posedge clk) begin
      if (rst) begin
         sect_powered <= '0;
         fuse_locked <= '0;
         fuse_burn <= '0;
         current_page <= ssf_page_reset;
      end else begin
         sect_powered <= powered;
         current_page <= page;
         for (int i = 0; i < ssf_nsect; i++) begin
            fuse_locked[i] <= fuse_reg[i][7:6] == ssf_fuse_lock_val; // see R16
            // One-cycle burn pulse, only for a powered section
            fuse_burn[i] <= wr_burn && sidx == 3'(i) && powered[i] &&
                            link.wdata[7:3] == ssf_fuse_burn_val; // see R17
         end
      end
   end
endmodule

/* logic/ssf_host.sv */
// Host end: takes operations from software registers and runs them as
// paged register transactions on the link. Device answers reads next cycle.
`timescale 1ns/1ps
module ssf_host
   import ssf_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   ssf_if.host link,
   input wire logic [3:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   output logic [7:0] cmd_rdata
);
   typedef enum {h_idle, h_page, h_sel, h_rd, h_wait, h_cap, h_wr2, h_done} ssf_hstate_t;
   ssf_hstate_t st;
   logic [2:0] op;
   logic [7:0] arg;
   logic [7:0] result;
   logic [1:0] nreads;
   logic busy;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   wire logic start;
   wire logic [7:0] sel_val;
   wire logic [7:0] data_addr;
   wire logic [7:0] next_cmd_rdata;

   assign start = cmd_wr && cmd_addr == ssf_cmd_ctrl && !busy;
   assign sel_val = op == ssf_op_holdover ? ssf_sel_holdover :
                    op == ssf_op_lock ? ssf_notify_unmask :
                    arg == ssf_page_output ? ssf_sel_state_out :
                    arg >= ssf_page_loop_a ? ssf_sel_state_loop : ssf_sel_state;
   assign data_addr = op == ssf_op_holdover ? ssf_reg_ho_data :
                      op == ssf_op_lock ? ssf_reg_lock_loss : ssf_reg_state_data;
   assign next_cmd_rdata = !cmd_rd ? 8'h00 :
                           cmd_addr == ssf_cmd_status ? {7'h0, busy} :
                           cmd_addr == ssf_cmd_arg ? arg :
                           cmd_addr == ssf_cmd_result ? result : 8'h00;

   always_ff @(posedge clk) begin
      if (rst) begin
         st <= h_idle;
         op <= ssf_op_state;
         arg <= ssf_page_reset;
         result <= 8'h00;
         nreads <= 2'd0;
         busy <= 1'b0;
         addr <= 8'h00;
         wdata <= 8'h00;
         wr <= 1'b0;
         rd <= 1'b0;
         cmd_rdata <= 8'h00;
      end else begin
         cmd_rdata <= next_cmd_rdata;
         wr <= 1'b0;
         rd <= 1'b0;
         if (cmd_wr && cmd_addr == ssf_cmd_arg && !busy) begin
            arg <= cmd_wdata;
         end
         case (st)
            h_idle: if (start) begin
               op <= cmd_wdata[2:0];
               busy <= 1'b1;
               st <= h_page;
            end
            h_page: begin
               // Wake-off always targets the master page
               wr <= 1'b1;
               addr <= ssf_reg_page;
               wdata <= op == ssf_op_wake_off ? ssf_page_master : arg; // see R1 R2
               st <= h_sel;
            end
            h_sel: begin
               wr <= 1'b1;
               nreads <= 2'd0;
               if (op == ssf_op_fuse) begin
                  addr <= ssf_reg_fuse_lock;
                  wdata <= {ssf_fuse_lock_val, 6'h00}; // see R16 R15
                  st <= h_wr2;
               end else if (op == ssf_op_wake_off) begin
                  addr <= ssf_reg_fuse_lock;
                  wdata <= 8'(32'h1 << ssf_wake_off_bit); // see R18
                  st <= h_done;
               end else begin
                  addr <= op == ssf_op_holdover ? ssf_reg_ho_select :
                          op == ssf_op_lock ? ssf_reg_notify_mask : ssf_reg_state_sel;
                  wdata <= sel_val; // see R3 R10 R12
                  st <= h_rd;
               end
            end
            h_rd: begin
               rd <= 1'b1;
               addr <= data_addr;
               st <= h_wait;
            end
            h_wait: begin
               // Read data stand in the cycle after the strobe
               st <= h_cap;
            end
            h_cap: begin
               // Keep the last of three reads, without comparing them
               result <= link.rdata;
               nreads <= nreads + 2'd1;
               st <= nreads == 2'(ssf_state_reads - 1) ? h_done : h_rd; // see R8
            end
            h_wr2: begin
               wr <= 1'b1;
               addr <= ssf_reg_fuse_burn;
               wdata <= {ssf_fuse_burn_val, 3'h0}; // see R17
               st <= h_done;
            end
            h_done: begin
               busy <= 1'b0;
               st <= h_idle;
            end
            default: st <= h_idle;
         endcase
      end
   end

   assign link.addr = addr;
   assign link.wdata = wdata;
   assign link.wr = wr;
   assign link.rd = rd;
endmodule

/* testbench/ssf_properties.sv */
// Checker for the paged register link between host end and device end.
// Takes the link signals as plain inputs; placed beside the link.
`timescale 1ns/1ps
module ssf_properties
   import ssf_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata
);
   logic [7:0] page;
   logic [7:0] ho_sel;
   logic sel_ok;
   logic sel_wr;
   logic locked;
   logic [1:0] nrd;
   wire wr_pg = wr && addr == ssf_reg_page;
   wire wr_sel = wr && addr == ssf_reg_state_sel;
   wire wr_lock = wr && addr == ssf_reg_fuse_lock && wdata[7:6] == ssf_fuse_lock_val;
   wire rd_st = rd && addr == ssf_reg_state_data;
   wire loop_pg = page >= ssf_page_loop_a && page <= ssf_page_loop_d;
   wire [7:0] want_sel = (page == ssf_page_output) ? ssf_sel_state_out :
      loop_pg ? ssf_sel_state_loop : ssf_sel_state;
   // Mirror of page, selectors and read count as seen on the link
   always_ff @(posedge clk) begin
      if (rst) begin
         page <= ssf_page_reset;
         ho_sel <= 8'h00;
         sel_ok <= 1'b0;
         sel_wr <= 1'b0;
         locked <= 1'b0;
         nrd <= 2'h0;
      end else begin
         page <= wr_pg ? wdata : page;
         ho_sel <= (wr && addr == ssf_reg_ho_select) ? wdata : ho_sel;
         sel_ok <= wr_pg ? 1'b0 : wr_sel ? wdata == want_sel : sel_ok;
         sel_wr <= wr_pg ? 1'b0 : wr_sel ? 1'b1 : sel_wr;
         locked <= wr_pg ? 1'b0 : wr_lock ? 1'b1 : locked;
         nrd <= wr_sel ? 2'h0 : (rd_st && nrd != 2'h3) ? nrd + 2'h1 : nrd;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   a_page_valid: assert property (wr_pg |-> wdata <= 8'h03 ||
      (wdata >= ssf_page_loop_a && wdata <= ssf_page_loop_d))
      else $error("page code outside the documented set");
   a_select_first: assert property (rd_st |-> sel_ok)
      else $error("status data read without the page selector");
   a_master_code: assert property (rd_st && page == ssf_page_master |=>
      rdata inside {8'h00, 8'h09, 8'h24})
      else $error("master state code outside its set");
   a_slave_code: assert property (rd_st && sel_ok && page inside {8'h01, 8'h02, 8'h03} |=>
      ($past(page) == 8'h01 && rdata[3:0] inside {4'h0, 4'h5, 4'hc}) ||
      ($past(page) == 8'h02 && rdata[4:0] inside {5'h00, 5'h07, 5'h17}) ||
      ($past(page) == 8'h03 && rdata[4:0] inside {5'h00, 5'h0c, 5'h14}))
      else $error("section state code outside its set");
   a_loop_code: assert property (rd_st && sel_ok && loop_pg |=>
      rdata inside {8'h00, 8'h08, 8'h30})
      else $error("loop state code outside its set");
   a_three_reads: assert property (wr_pg && sel_wr |-> nrd == 2'h3)
      else $error("status query left with fewer than three reads");
   a_holdover_sel: assert property (rd && addr == ssf_reg_ho_data |->
      ho_sel == ssf_sel_holdover)
      else $error("holdover data read without its selector");
   a_burn_locked: assert property (wr && addr == ssf_reg_fuse_burn &&
      wdata[7:3] == ssf_fuse_burn_val |-> locked)
      else $error("fuse burn issued before the page lock");
   c_state_read: cover property (rd_st && sel_ok);
   c_burn: cover property (wr && addr == ssf_reg_fuse_burn && locked);
   c_holdover: cover property (rd && addr == ssf_reg_ho_data);
endmodule

/* testbench/subsystem_status_and_fuse_programming_tb.sv */
// Bench: host end drives one device over the link; a second device is
// driven straight by the bench for page, force, state code, loop status and fuse accesses.
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
   $display("CHECK FAILED at %0t: got %h expected %h", $time, (a), (e)); end end
module subsystem_status_and_fuse_programming_tb
   import ssf_pkg::*;
();
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] cmd_addr = 4'h0;
   logic [7:0] cmd_wdata = 8'h00;
   logic cmd_wr = 1'b0;
   logic cmd_rd = 1'b0;
   logic [7:0] cmd_rdata;
   logic [3:0] unl = 4'h0;
   logic [3:0] hold = 4'h0;
   logic [7:0] act = 8'h00;
   logic [7:0] pw1, lk1, fb1, pg1, pw2, lk2, fb2, pg2;
   logic wo1, wo2;
   int err_total = 0;
   int cmp_count = 0;
   int burn1 = 0;
   int burn2 = 0;
   logic [7:0] seen2 = 8'h00;
   ssf_if link();
   ssf_if link2();
   ssf_host u_ssf_host (.clk(clk), .rst(rst), .link(link.host), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata));
   ssf_device u_ssf_device (.clk(clk), .rst(rst), .link(link.device), .loop_unlocked(unl),
      .loop_holdover(hold), .sect_active(act), .sect_powered(pw1), .fuse_locked(lk1),
      .fuse_burn(fb1), .manual_wake_off(wo1), .current_page(pg1));
   ssf_device u_ssf_device2 (.clk(clk), .rst(rst), .link(link2.device), .loop_unlocked(unl),
      .loop_holdover(hold), .sect_active(act), .sect_powered(pw2), .fuse_locked(lk2),
      .fuse_burn(fb2), .manual_wake_off(wo2), .current_page(pg2));
   ssf_properties u_ssf_properties (.clk(clk), .rst(rst), .addr(link.addr),
      .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata));
   initial begin
      forever #2 clk = ~clk;
   end
   // Burn pulse counters
   always @(posedge clk) begin
      if (!rst) begin
         burn1 <= burn1 + int'(fb1 != 8'h00);
         burn2 <= burn2 + int'(fb2 != 8'h00);
         seen2 <= seen2 | fb2;
      end
   end
   function automatic logic [7:0] pcode(int i);
      return (i < 4) ? 8'(i) : 8'(i + 6);
   endfunction
   function automatic logic [7:0] scode(int i, bit a);
      case (i)
         0: return a ? ssf_code_master_act : ssf_code_master_wait;
         1: return a ? ssf_code_clk_act : ssf_code_clk_wait;
         2: return a ? ssf_code_in_act : ssf_code_in_wait;
         3: return a ? ssf_code_out_act : ssf_code_out_wait;
         default: return a ? ssf_code_loop_act : ssf_code_loop_wait;
      endcase
   endfunction
   // One strobe cycle on the command port (h) or the second link
   task automatic xfer(input bit h, input bit w, input logic [7:0] a, input logic [7:0] d,
         output logic [7:0] q);
      if (h) begin
         cmd_addr <= a[3:0];
         cmd_wdata <= d;
         cmd_wr <= w;
         cmd_rd <= !w;
      end else begin
         link2.addr <= a;
         link2.wdata <= d;
         link2.wr <= w;
         link2.rd <= !w;
      end
      @(posedge clk);
      cmd_wr <= 1'b0;
      cmd_rd <= 1'b0;
      link2.wr <= 1'b0;
      link2.rd <= 1'b0;
      #1 q = h ? cmd_rdata : link2.rdata;
      repeat (3) @(posedge clk);
   endtask
   task automatic dw(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      xfer(1'b0, 1'b1, a, d, q);
   endtask
   task automatic dr(input logic [7:0] a, output logic [7:0] q);
      xfer(1'b0, 1'b0, a, 8'h00, q);
   endtask
   task automatic run_op(input logic [2:0] op, input logic [7:0] arg, output logic [7:0] res);
      logic [7:0] q;
      int n;
      xfer(1'b1, 1'b1, {4'h0, ssf_cmd_arg}, arg, q);
      xfer(1'b1, 1'b1, {4'h0, ssf_cmd_ctrl}, {5'h00, op}, q);
      n = 0;
      q = 8'h01;
      while (q[0] !== 1'b0 && n < 200) begin
         xfer(1'b1, 1'b0, {4'h0, ssf_cmd_status}, 8'h00, q);
         n++;
      end
      `CHK(n < 200, 1'b1)
      xfer(1'b1, 1'b0, {4'h0, ssf_cmd_result}, 8'h00, res);
   endtask
   task automatic t_pages();
      logic [7:0] q;
      for (int i = 0; i < 8; i++) begin
         dw(ssf_reg_page, pcode(i));
         `CHK(pg2, pcode(i))
         dr(ssf_reg_page, q);
         `CHK(q, pcode(i))
      end
      dr(8'h55, q);
      `CHK(q, 8'h00)
   endtask
   task automatic t_power();
      logic [7:0] en;
      dw(ssf_reg_page, ssf_page_master);
      dw(ssf_reg_force_en, 8'h7f);
      dw(ssf_reg_force_ovr, 8'h00);
      `CHK(pw2, 8'h01)
      dw(ssf_reg_force_ovr, 8'h7f);
      for (int i = 0; i < 8; i++) begin
         en = (i < 7) ? 8'h01 << i : 8'h7f;
         dw(ssf_reg_force_en, en);
         `CHK(pw2, {en[6:3], en[2], en[0], en[1], 1'b1})
      end
   endtask
   task automatic t_codes();
      logic [7:0] q;
      logic [7:0] m;
      for (int a = 0; a < 2; a++) begin
         act <= a[0] ? 8'hff : 8'h00;
         for (int i = 0; i < 8; i++) begin
            m = (i == 1) ? 8'h0f : (i == 2 || i == 3) ? 8'h1f : 8'hff;
            dw(ssf_reg_page, pcode(i));
            dw(ssf_reg_state_sel, (i == 3) ? ssf_sel_state_out :
               (i > 3) ? ssf_sel_state_loop : ssf_sel_state);
            repeat (3) begin
               dr(ssf_reg_state_data, q);
               `CHK(q & m, scode(i, a[0]))
            end
         end
      end
   endtask
   task automatic t_loop2();
      logic [7:0] q;
      dw(ssf_reg_page, ssf_page_loop_d);
      unl <= 4'h8;
      dw(ssf_reg_notify_mask, 8'h00);
      dr(ssf_reg_lock_loss, q);
      `CHK(q[0], 1'b0)
      dw(ssf_reg_notify_mask, ssf_notify_unmask);
      dr(ssf_reg_lock_loss, q);
      `CHK(q[0], 1'b1)
      dw(ssf_reg_outer_cfg, 8'h80);
      dr(ssf_reg_outer_cfg, q);
      `CHK(q, 8'h80)
      dw(ssf_reg_ho_select, ssf_sel_holdover);
      dr(ssf_reg_ho_data, q);
      `CHK(q[3], 1'b1)
      dw(ssf_reg_ho_select, 8'h00);
      dr(ssf_reg_ho_data, q);
      `CHK(q[3], 1'b0)
      dw(ssf_reg_page, ssf_page_master);
      dr(ssf_reg_outer_cfg, q);
      `CHK(q, 8'h00)
      unl <= 4'h0;
   endtask
   task automatic t_fuse();
      logic [7:0] q;
      int b;
      dw(ssf_reg_page, ssf_page_input);
      dw(ssf_reg_fuse_lock, 8'h40);
      `CHK(lk2, 8'h04)
      b = burn2;
      dw(ssf_reg_fuse_burn, 8'h58);
      `CHK(burn2 - b, 0)
      dw(ssf_reg_fuse_burn, 8'h60);
      `CHK(burn2 - b, 1)
      `CHK(seen2, 8'h04)
      dw(ssf_reg_page, ssf_page_master);
      dw(ssf_reg_force_ovr, 8'h00);
      dw(ssf_reg_page, ssf_page_output);
      dw(ssf_reg_fuse_burn, 8'h60);
      `CHK(burn2 - b, 1)
      dw(ssf_reg_state_sel, ssf_sel_state_out);
      dr(ssf_reg_state_data, q);
      `CHK(q[4:0], 5'h00)
      dw(ssf_reg_page, ssf_page_master);
      dw(ssf_reg_fuse_lock, 8'h10);
      `CHK({wo2, lk2[0]}, 2'h2)
   endtask
   task automatic t_host();
      logic [7:0] r;
      act <= 8'h00;
      run_op(ssf_op_state, ssf_page_master, r);
      `CHK(r, ssf_code_master_wait)
      act <= 8'h01;
      run_op(ssf_op_state, ssf_page_master, r);
      `CHK(r, ssf_code_master_act)
      run_op(ssf_op_state, ssf_page_clk_sup, r);
      `CHK(r[3:0], 4'h0)
      run_op(ssf_op_state, 8'h0b, r);
      `CHK(r, ssf_code_idle)
      for (int v = 1; v >= 0; v--) begin
         unl <= v[0] ? 4'h2 : 4'h0;
         hold <= v[0] ? 4'h4 : 4'h0;
         run_op(ssf_op_lock, 8'h0b, r);
         `CHK(r[0], v[0])
         run_op(ssf_op_holdover, 8'h0c, r);
         `CHK(r[3], v[0])
      end
      run_op(ssf_op_fuse, ssf_page_master, r);
      `CHK(burn1, 1)
      `CHK(lk1[0], 1'b1)
      run_op(ssf_op_wake_off, ssf_page_master, r);
      `CHK(wo1, 1'b1)
   endtask
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      #50000;
      err_total++;
      summarize();
   end
   initial begin
      link2.addr = 8'h00;
      link2.wdata = 8'h00;
      link2.wr = 1'b0;
      link2.rd = 1'b0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      `CHK({pg1, pg2, lk1, lk2, wo1, wo2}, 34'h0)
      t_pages();
      t_power();
      t_codes();
      t_loop2();
      t_fuse();
      t_host();
      summarize();
   end
endmodule
